//--- src/sea_regs.svh
// constants shared by both ends of the serial eeprom link
`ifndef SEA_REGS_SVH
`define SEA_REGS_SVH
// device select low bits and direction codes
`define SEA_CE_BITS 3'h0
`define SEA_DIR_WR 1'h0
`define SEA_DIR_RD 1'h1
// array organisation: 15 address bits kept, 64-byte rows
`define SEA_ADDR_W 15
`define SEA_MEM_BYTES 32768
`define SEA_PAGE_W 6
`define SEA_PAGE_BYTES 64
// byte framing: 8 data bits then the acknowledge slot
`define SEA_BYTE_BITS 4'h8
`define SEA_IDX_ADDRH 2'h1
`define SEA_IDX_ADDRL 2'h2
`define SEA_IDX_DATA 2'h3
// timing: system clock, self-timed write, serial clock period
`define SEA_CLK_NS 100
`define SEA_TW_NS 10000000
`define SEA_TW_CYC (`SEA_TW_NS / `SEA_CLK_NS)
`define SEA_SCL_NS 2500
`define SEA_QTR_CYC ((`SEA_SCL_NS / 4 + `SEA_CLK_NS - 1) / `SEA_CLK_NS)
`endif

//--- src/sea_pkg.sv
// types shared by both ends of the serial eeprom link
package sea_pkg;
	// device sequencer states
	typedef enum logic [5:0] {
		DS_IDLE = 6'h01,
		DS_RX = 6'h02,
		DS_ACK = 6'h04,
		DS_TX = 6'h08,
		DS_MACK = 6'h10,
		DS_BUSY = 6'h20
	} sea_dev_st_t;
	// bus master states
	typedef enum logic [7:0] {
		MS_IDLE = 8'h01,
		MS_START = 8'h02,
		MS_DEV = 8'h04,
		MS_ADDRH = 8'h08,
		MS_ADDRL = 8'h10,
		MS_WDATA = 8'h20,
		MS_RDATA = 8'h40,
		MS_STOP = 8'h80
	} sea_mst_st_t;
	// master commands
	typedef enum logic [1:0] {
		OP_WRITE = 2'h0,
		OP_RAND = 2'h1,
		OP_CUR = 2'h2
	} sea_op_t;
endpackage

//--- src/sea_if.sv
// two-wire link between bus master and eeprom device
`timescale 1ns/1ps
interface sea_if;
	// serial clock, driven push-pull by the master
	logic scl;
	// open-drain data pins of each end
	logic mstSdaOut;
	logic mstSdaOe;
	logic devSdaOut;
	logic devSdaOe;
	// resolved data line with pull-up
	logic sda;
	assign sda = ~((mstSdaOe & ~mstSdaOut) | (devSdaOe & ~devSdaOut));
	modport master (output scl, output mstSdaOut, output mstSdaOe, input sda);
	modport dev (input scl, input sda, output devSdaOut, output devSdaOe);
endinterface

//--- src/sea_eeprom_dev.sv
// eeprom end: command sequencer, page buffer, self-timed write and array
// Summary of operation
// - write select acked, then two acked address bytes
// - address high byte first, top bit ignored
// - protect seen before data blocks write, nacks data
// - byte write acked only when writing allowed
// - page holds 1 to 64 bytes, one row
// - page write increments only low six bits
// - excess page bytes wrap, overwriting earlier data
// - write starts only on STOP after data ack
// - busy writing: ignore line, no acknowledge
// - master polls select until device acknowledges
// - reads ignore the write protect input
// - random read: address write, restart, read
// - master repeats identical select bits on restart
// - current read outputs counter byte, then increments
// - ack select only on matching type code
// - master nack after read byte ends transfer
// - sequential read wraps from top to zero
// - sample data on rising clock, msb first
`timescale 1ns/1ps
`include "sea_regs.svh"
module sea_eeprom_dev
	import sea_pkg::*;
#(
	parameter int unsigned writeCycles = `SEA_TW_CYC,
	parameter logic [3:0] devType = 4'h6 // arbitrary type code
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// two-wire link
	sea_if.dev bus,
	// user side
	input wire logic writeProtectInput,
	output logic busy
);
	////////////////////////////////////////////////////////////////
	// pin synchronisers and line events
	logic sclS1_r;
	logic sclS2_r;
	logic sdaS1_r;
	logic sdaS2_r;
	logic wpS1_r;
	logic wpS2_r;
	logic sclD_r;
	logic sdaD_r;
	logic sclRise;
	logic sclFall;
	logic startSeen;
	logic stopSeen;

	// two flops per pin, then one delay stage for edges
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sclS1_r <= 1'h1;
			sclS2_r <= 1'h1;
			sdaS1_r <= 1'h1;
			sdaS2_r <= 1'h1;
			wpS1_r <= 1'h0;
			wpS2_r <= 1'h0;
			sclD_r <= 1'h1;
			sdaD_r <= 1'h1;
		end
		else
		begin
			sclS1_r <= bus.scl;
			sclS2_r <= sclS1_r;
			sdaS1_r <= bus.sda;
			sdaS2_r <= sdaS1_r;
			wpS1_r <= writeProtectInput;
			wpS2_r <= wpS1_r;
			sclD_r <= sclS2_r;
			sdaD_r <= sdaS2_r;
		end
	end

	// data edges while clock is high are start and stop
	assign sclRise = sclS2_r & ~sclD_r;
	assign sclFall = ~sclS2_r & sclD_r;
	assign startSeen = sclS2_r & sclD_r & sdaD_r & ~sdaS2_r;
	assign stopSeen = sclS2_r & sclD_r & ~sdaD_r & sdaS2_r;

	////////////////////////////////////////////////////////////////
	// sequencer state
	sea_dev_st_t st_r, st_nxt;
	logic [3:0] bitCnt_r, bitCnt_nxt;
	logic [1:0] byteIdx_r, byteIdx_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic rnw_r, rnw_nxt;
	logic wpSeen_r, wpSeen_nxt;
	logic oe_r, oe_nxt;
	logic [`SEA_ADDR_W-1:0] addr_r, addr_nxt;
	logic [7:0] pageBuf_r [`SEA_PAGE_BYTES];
	logic [7:0] pageBuf_nxt [`SEA_PAGE_BYTES];
	logic [`SEA_PAGE_BYTES-1:0] pageVld_r, pageVld_nxt;
	logic [31:0] busyCnt_r, busyCnt_nxt;
	logic commit;
	logic [7:0] mem_r [`SEA_MEM_BYTES];

	// next values of the sequencer
	always_comb
	begin
		st_nxt = st_r;
		bitCnt_nxt = bitCnt_r;
		byteIdx_nxt = byteIdx_r;
		shift_nxt = shift_r;
		rnw_nxt = rnw_r;
		wpSeen_nxt = wpSeen_r;
		oe_nxt = oe_r;
		addr_nxt = addr_r;
		pageBuf_nxt = pageBuf_r;
		pageVld_nxt = pageVld_r;
		busyCnt_nxt = busyCnt_r;
		commit = 1'h0;
		if (st_r == DS_BUSY)
		begin
			// line ignored until the write time has run out
			oe_nxt = 1'h0;
			busyCnt_nxt = busyCnt_r + 32'h0000_0001;
			if (busyCnt_r == writeCycles - 1)
			begin
				commit = 1'h1;
				pageVld_nxt = '0;
				st_nxt = DS_IDLE;
			end
		end
		else if (startSeen)
		begin
			// start or repeated start: expect a select byte
			st_nxt = DS_RX;
			bitCnt_nxt = 4'h0;
			byteIdx_nxt = 2'h0;
			wpSeen_nxt = wpS2_r;
			oe_nxt = 1'h0;
		end
		else if (stopSeen)
		begin
			oe_nxt = 1'h0;
			pageVld_nxt = '0;
			st_nxt = DS_IDLE;
			// only a stop in the slot right after a data ack starts a write;
			// that slot's rising clock edge has already been counted
			if (st_r == DS_RX && bitCnt_r == 4'h1 && byteIdx_r == `SEA_IDX_DATA
				&& !rnw_r && |pageVld_r)
			begin
				pageVld_nxt = pageVld_r;
				busyCnt_nxt = 32'h0000_0000;
				st_nxt = DS_BUSY;
			end
		end
		else
		begin
			unique case (st_r)
				DS_IDLE:
				begin
					oe_nxt = 1'h0;
				end
				DS_RX:
				begin
					// protect level counts up to the end of the address
					if (byteIdx_r != `SEA_IDX_DATA && wpS2_r)
						wpSeen_nxt = 1'h1;
					if (sclRise)
					begin
						shift_nxt = {shift_r[6:0], sdaS2_r};
						bitCnt_nxt = bitCnt_r + 4'h1;
					end
					else if (sclFall && bitCnt_r == `SEA_BYTE_BITS)
					begin
						bitCnt_nxt = 4'h0;
						st_nxt = DS_ACK;
						oe_nxt = 1'h1;
						if (byteIdx_r != `SEA_IDX_DATA)
							byteIdx_nxt = byteIdx_r + 2'h1;
						unique case (byteIdx_r)
							2'h0:
							begin
								rnw_nxt = shift_r[0];
								if (shift_r[7:1] != {devType, `SEA_CE_BITS})
								begin
									oe_nxt = 1'h0;
									st_nxt = DS_IDLE;
								end
							end
							`SEA_IDX_ADDRH:
								addr_nxt[`SEA_ADDR_W-1:8] = shift_r[6:0];
							`SEA_IDX_ADDRL:
								addr_nxt[7:0] = shift_r;
							`SEA_IDX_DATA:
							begin
								// data byte: latch into page, step within row
								oe_nxt = ~wpSeen_r;
								if (!wpSeen_r)
								begin
									pageBuf_nxt[addr_r[`SEA_PAGE_W-1:0]] = shift_r;
									pageVld_nxt[addr_r[`SEA_PAGE_W-1:0]] = 1'h1;
									addr_nxt[`SEA_PAGE_W-1:0] =
										addr_r[`SEA_PAGE_W-1:0] + 6'h01;
								end
							end
						endcase
					end
				end
				DS_ACK:
				begin
					if (sclFall)
					begin
						oe_nxt = 1'h0;
						st_nxt = DS_RX;
						// read select: drive the first bit right away
						if (byteIdx_r == `SEA_IDX_ADDRH && rnw_r)
						begin
							shift_nxt = mem_r[addr_r];
							oe_nxt = ~mem_r[addr_r][7];
							bitCnt_nxt = 4'h1;
							st_nxt = DS_TX;
						end
					end
				end
				DS_TX:
				begin
					if (sclFall)
					begin
						bitCnt_nxt = bitCnt_r + 4'h1;
						if (bitCnt_r == 4'h0)
						begin
							// next byte of a sequential read
							shift_nxt = mem_r[addr_r];
							oe_nxt = ~mem_r[addr_r][7];
						end
						else if (bitCnt_r == `SEA_BYTE_BITS)
						begin
							oe_nxt = 1'h0; // release for the master ack
							st_nxt = DS_MACK;
						end
						else
						begin
							shift_nxt = {shift_r[6:0], 1'h1};
							oe_nxt = ~shift_r[6];
						end
					end
				end
				DS_MACK:
				begin
					if (sclRise)
					begin
						addr_nxt = addr_r + 15'h0001;
						bitCnt_nxt = 4'h0;
						st_nxt = sdaS2_r ? DS_IDLE : DS_TX;
					end
				end
				default:
				begin
					st_nxt = DS_IDLE;
				end
			endcase
		end
	end

	// sequencer registers
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_r <= DS_IDLE;
			bitCnt_r <= 4'h0;
			byteIdx_r <= 2'h0;
			shift_r <= 8'h00;
			rnw_r <= 1'h0;
			wpSeen_r <= 1'h0;
			oe_r <= 1'h0;
			addr_r <= 15'h0000;
			pageBuf_r <= '{default: 8'h00};
			pageVld_r <= '0;
			busyCnt_r <= 32'h0000_0000;
		end
		else
		begin
			st_r <= st_nxt;
			bitCnt_r <= bitCnt_nxt;
			byteIdx_r <= byteIdx_nxt;
			shift_r <= shift_nxt;
			rnw_r <= rnw_nxt;
			wpSeen_r <= wpSeen_nxt;
			oe_r <= oe_nxt;
			addr_r <= addr_nxt;
			pageBuf_r <= pageBuf_nxt;
			pageVld_r <= pageVld_nxt;
			busyCnt_r <= busyCnt_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// memory array, erased to all ones; only the loaded bytes of the row written at commit
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			mem_r <= '{default: 8'hFF};
		else if (commit)
		begin
			for (int i = 0; i < `SEA_PAGE_BYTES; i++)
			begin
				if (pageVld_r[i])
					mem_r[{addr_r[`SEA_ADDR_W-1:`SEA_PAGE_W], i[`SEA_PAGE_W-1:0]}] <=
						pageBuf_r[i];
			end
		end
	end

	// open-drain data pin and status
	assign bus.devSdaOut = 1'h0;
	assign bus.devSdaOe = oe_r;
	assign busy = (st_r == DS_BUSY);
endmodule

//--- src/sea_bus_master.sv
// bus master end: clock divider and command sequencer for the eeprom
`timescale 1ns/1ps
`include "sea_regs.svh"
module sea_bus_master
	import sea_pkg::*;
#(
	parameter logic [3:0] devType = 4'h6 // arbitrary type code
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// two-wire link
	sea_if.master bus,
	// command request
	input wire logic reqValid,
	output logic reqReady,
	input wire sea_op_t reqOp,
	input wire logic [15:0] reqAddr,
	input wire logic [7:0] reqLen,
	// write data stream
	input wire logic [7:0] wrData,
	input wire logic wrValid,
	output logic wrReady,
	// read data and completion
	output logic [7:0] rdData,
	output logic rdValid,
	output logic done,
	output logic dataNack
);
	////////////////////////////////////////////////////////////////
	// data line synchroniser
	logic sdaS1_r;
	logic sdaS2_r;

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sdaS1_r <= 1'h1;
			sdaS2_r <= 1'h1;
		end
		else
		begin
			sdaS1_r <= bus.sda;
			sdaS2_r <= sdaS1_r;
		end
	end

	////////////////////////////////////////////////////////////////
	// sequencer: each bit is four quarters of the serial clock
	sea_mst_st_t st_r, st_nxt;
	logic [7:0] qCnt_r, qCnt_nxt;
	logic [1:0] ph_r, ph_nxt;
	logic [3:0] bitCnt_r, bitCnt_nxt;
	logic [8:0] tx_r, tx_nxt;
	logic [8:0] rx_r, rx_nxt;
	logic scl_r, scl_nxt;
	logic sda_r, sda_nxt;
	sea_op_t op_r, op_nxt;
	logic [15:0] addr_r, addr_nxt;
	logic [7:0] left_r, left_nxt;
	logic rnw_r, rnw_nxt;
	logic retry_r, retry_nxt;
	logic [7:0] rdData_r, rdData_nxt;
	logic rdValid_r, rdValid_nxt;
	logic done_r, done_nxt;
	logic nack_r, nack_nxt;
	logic tick;
	logic ack;

	assign tick = (qCnt_r == 8'(`SEA_QTR_CYC - 1));
	assign ack = ~rx_r[0];

	// next values of the sequencer
	always_comb
	begin
		st_nxt = st_r;
		qCnt_nxt = tick ? 8'h00 : qCnt_r + 8'h01;
		ph_nxt = ph_r;
		bitCnt_nxt = bitCnt_r;
		tx_nxt = tx_r;
		rx_nxt = rx_r;
		scl_nxt = scl_r;
		sda_nxt = sda_r;
		op_nxt = op_r;
		addr_nxt = addr_r;
		left_nxt = left_r;
		rnw_nxt = rnw_r;
		retry_nxt = retry_r;
		rdData_nxt = rdData_r;
		rdValid_nxt = 1'h0;
		done_nxt = 1'h0;
		nack_nxt = nack_r;
		wrReady = 1'h0;
		if (st_r == MS_IDLE)
		begin
			qCnt_nxt = 8'h00;
			ph_nxt = 2'h0;
			scl_nxt = 1'h1;
			sda_nxt = 1'h1;
			if (reqValid)
			begin
				op_nxt = reqOp;
				addr_nxt = reqAddr;
				left_nxt = reqLen;
				rnw_nxt = (reqOp == OP_CUR) ? `SEA_DIR_RD : `SEA_DIR_WR;
				nack_nxt = 1'h0;
				retry_nxt = 1'h0;
				st_nxt = MS_START;
			end
		end
		else if (tick)
		begin
			ph_nxt = ph_r + 2'h1;
			unique case (st_r)
				MS_START:
				begin
					// sda falls while scl high, then scl low
					unique case (ph_r)
						2'h0: sda_nxt = 1'h1;
						2'h1: scl_nxt = 1'h1;
						2'h2: sda_nxt = 1'h0;
						2'h3:
						begin
							scl_nxt = 1'h0;
							tx_nxt = {devType, `SEA_CE_BITS, rnw_r, 1'h1};
							bitCnt_nxt = 4'h0;
							st_nxt = MS_DEV;
						end
					endcase
				end
				MS_STOP:
				begin
					// sda rises while scl high
					unique case (ph_r)
						2'h0: sda_nxt = 1'h0;
						2'h1: scl_nxt = 1'h1;
						2'h2: sda_nxt = 1'h1;
						2'h3:
						begin
							st_nxt = retry_r ? MS_START : MS_IDLE;
							done_nxt = ~retry_r;
						end
					endcase
				end
				default:
				begin
					// byte states: change data only while scl is low
					unique case (ph_r)
						2'h0: sda_nxt = tx_r[8];
						2'h1: scl_nxt = 1'h1;
						2'h2: rx_nxt = {rx_r[7:0], sdaS2_r};
						2'h3:
						begin
							scl_nxt = 1'h0;
							tx_nxt = {tx_r[7:0], 1'h1};
							bitCnt_nxt = bitCnt_r + 4'h1;
						end
					endcase
					if (ph_r == 2'h3 && bitCnt_r == `SEA_BYTE_BITS)
					begin
						bitCnt_nxt = 4'h0;
						st_nxt = MS_STOP;
						unique case (st_r)
							MS_DEV:
							begin
								// no ack means busy: stop and poll again
								retry_nxt = ~ack;
								if (ack && rnw_r)
								begin
									tx_nxt = {8'hFF, left_r <= 8'h01};
									st_nxt = MS_RDATA;
								end
								else if (ack)
								begin
									tx_nxt = {addr_r[15:8], 1'h1};
									st_nxt = MS_ADDRH;
								end
							end
							MS_ADDRH:
							begin
								tx_nxt = {addr_r[7:0], 1'h1};
								st_nxt = MS_ADDRL;
							end
							MS_ADDRL, MS_WDATA:
							begin
								if (op_r == OP_RAND)
								begin
									rnw_nxt = `SEA_DIR_RD;
									st_nxt = MS_START;
								end
								else if (st_r == MS_WDATA && !ack)
									nack_nxt = 1'h1;
								else if (wrValid)
								begin
									wrReady = 1'h1;
									tx_nxt = {wrData, 1'h1};
									st_nxt = MS_WDATA;
								end
							end
							MS_RDATA:
							begin
								rdData_nxt = rx_r[8:1];
								rdValid_nxt = 1'h1;
								left_nxt = left_r - 8'h01;
								if (left_r > 8'h01)
								begin
									tx_nxt = {8'hFF, left_r <= 8'h02};
									st_nxt = MS_RDATA;
								end
							end
							default:
							begin
								st_nxt = MS_STOP;
							end
						endcase
					end
				end
			endcase
		end
	end

	// sequencer registers
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_r <= MS_IDLE;
			qCnt_r <= 8'h00;
			ph_r <= 2'h0;
			bitCnt_r <= 4'h0;
			tx_r <= 9'h1FF;
			rx_r <= 9'h1FF;
			scl_r <= 1'h1;
			sda_r <= 1'h1;
			op_r <= OP_WRITE;
			addr_r <= 16'h0000;
			left_r <= 8'h00;
			rnw_r <= 1'h0;
			retry_r <= 1'h0;
			rdData_r <= 8'h00;
			rdValid_r <= 1'h0;
			done_r <= 1'h0;
			nack_r <= 1'h0;
		end
		else
		begin
			st_r <= st_nxt;
			qCnt_r <= qCnt_nxt;
			ph_r <= ph_nxt;
			bitCnt_r <= bitCnt_nxt;
			tx_r <= tx_nxt;
			rx_r <= rx_nxt;
			scl_r <= scl_nxt;
			sda_r <= sda_nxt;
			op_r <= op_nxt;
			addr_r <= addr_nxt;
			left_r <= left_nxt;
			rnw_r <= rnw_nxt;
			retry_r <= retry_nxt;
			rdData_r <= rdData_nxt;
			rdValid_r <= rdValid_nxt;
			done_r <= done_nxt;
			nack_r <= nack_nxt;
		end
	end

	// pins and user outputs
	assign bus.scl = scl_r;
	assign bus.mstSdaOut = 1'h0;
	assign bus.mstSdaOe = ~sda_r;
	assign reqReady = (st_r == MS_IDLE);
	assign rdData = rdData_r;
	assign rdValid = rdValid_r;
	assign done = done_r;
	assign dataNack = nack_r;
endmodule

//--- tb/sea_link_sva.sv
// assertions on the two-wire link between bus master and eeprom device
`timescale 1ns/1ps
module sea_link_sva
#(
	parameter int unsigned writeCycles = 50
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// link lines
	input wire logic scl,
	input wire logic sda,
	input wire logic mstSdaOe,
	input wire logic devSdaOe,
	// device status
	input wire logic busy
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////////////
	// length of the current busy stretch
	int unsigned busyCnt_r;
	int unsigned busyCnt_nxt;
	// count cycles while the write cycle runs
	always_comb busyCnt_nxt = busy ? busyCnt_r + 1 : 0;
	// register the counter
	always_ff @(posedge mclk or negedge rst_n)
		if (!rst_n)
			busyCnt_r <= 0;
		else
			busyCnt_r <= busyCnt_nxt;

	////////////////////////////////////////////////////////////////////////////////
	// link rules
	a_busy_no_ack: assert property (busy |-> !devSdaOe)
		else $error("device drives data line while busy");
	a_busy_full_len: assert property ($fell(busy) |-> busyCnt_r == writeCycles)
		else $error("write cycle length differs from parameter");
	a_busy_after_stop: assert property ($rose(busy) |-> scl && sda && !$past(sda, 5))
		else $error("write cycle started without a stop");
	a_dev_drive_low: assert property ($rose(devSdaOe) |-> !scl ##1 devSdaOe [*8])
		else $error("device drive starts with clock high or is too short");
	a_dev_hold_high: assert property (scl && $past(scl) |-> $stable(devSdaOe))
		else $error("device data changes while clock high");
	a_edge_by_master: assert property ($fell(sda) && scl && $past(scl) |-> mstSdaOe && !devSdaOe)
		else $error("start condition not made by master alone");
	a_scl_high_width: assert property ($rose(scl) |-> scl [*8])
		else $error("serial clock high phase too short");
	a_scl_low_width: assert property ($fell(scl) |-> !scl [*8])
		else $error("serial clock low phase too short");

	// main scenarios
	c_write_cycle: cover property ($rose(busy));
	c_write_end: cover property ($fell(busy));
	c_dev_answer: cover property ($rose(devSdaOe) && !busy);
endmodule

//--- tb/tb.sv
// testbench: bus master and eeprom device joined over one link
`timescale 1ns/1ps
module tb;
	import sea_pkg::*;
	localparam int unsigned WCYC = 50;
	logic mclk;
	logic rst_n;
	logic wp;
	logic busy;
	logic reqValid;
	logic reqReady;
	sea_op_t reqOp;
	logic [15:0] reqAddr;
	logic [7:0] reqLen;
	logic [7:0] wrData;
	logic wrValid;
	logic wrReady;
	logic [7:0] rdData;
	logic rdValid;
	logic done;
	logic dataNack;
	logic busyPrev;
	int failCount;
	int cmpCount;
	int writeCount;
	logic [7:0] wrQ[$];
	logic [7:0] rdQ[$];

	////////////////////////////////////////////////////////////////////////////////
	// both ends and the checker
	sea_if link();
	sea_eeprom_dev #(.writeCycles(WCYC)) sea_eeprom_dev_inst (.mclk(mclk), .rst_n(rst_n),
		.bus(link.dev), .writeProtectInput(wp), .busy(busy));
	sea_bus_master sea_bus_master_inst (.mclk(mclk), .rst_n(rst_n), .bus(link.master),
		.reqValid(reqValid), .reqReady(reqReady), .reqOp(reqOp), .reqAddr(reqAddr),
		.reqLen(reqLen), .wrData(wrData), .wrValid(wrValid), .wrReady(wrReady),
		.rdData(rdData), .rdValid(rdValid), .done(done), .dataNack(dataNack));
	sea_link_sva #(.writeCycles(WCYC)) sea_link_sva_inst (.mclk(mclk), .rst_n(rst_n),
		.scl(link.scl), .sda(link.sda), .mstSdaOe(link.mstSdaOe),
		.devSdaOe(link.devSdaOe), .busy(busy));

	////////////////////////////////////////////////////////////////////////////////
	// clock and count of started write cycles
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		busyPrev <= busy;
		if (busy === 1'b1 && busyPrev === 1'b0)
			writeCount <= writeCount + 1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// shared tasks
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmpCount++;
		if (seen !== exp)
		begin
			failCount++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		if (failCount == 0 && cmpCount > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// one command; write bytes come from wrQ, read bytes go to rdQ
	task automatic run_cmd(input sea_op_t op, input logic [15:0] addr, input logic [7:0] len);
		int i;
		int t;
		i = 0;
		t = 0;
		rdQ.delete();
		reqValid = 1'b1;
		reqOp = op;
		reqAddr = addr;
		reqLen = len;
		wrValid = (wrQ.size() > 0);
		wrData = (wrQ.size() > 0) ? wrQ[0] : 8'h00;
		@(posedge mclk);
		#1 reqValid = 1'b0;
		while (t < 20000)
		begin
			@(posedge mclk);
			t++;
			if (rdValid === 1'b1)
				rdQ.push_back(rdData);
			if (done === 1'b1)
				break;
			if (wrReady === 1'b1)
			begin
				i++;
				#1 wrValid = (i < wrQ.size());
				wrData = (i < wrQ.size()) ? wrQ[i] : 8'h00;
			end
		end
		if (t >= 20000)
			check(8'h00, 8'h01);
		#1 wrValid = 1'b0;
		wrQ.delete();
	endtask

	// random read of len bytes and compare them with exp
	task automatic read_chk(input logic [15:0] addr, input logic [7:0] exp[$]);
		run_cmd(OP_RAND, addr, 8'(exp.size()));
		check(8'(rdQ.size()), 8'(exp.size()));
		foreach (exp[k])
			check(rdQ[k], exp[k]);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	// byte write with top address bit set, read back at once by polling
	task automatic sc_byte_write();
		int w;
		w = writeCount;
		wrQ = '{8'h5A};
		run_cmd(OP_WRITE, 16'h8123, 8'h01);
		check({7'h00, dataNack}, 8'h00);
		read_chk(16'h0123, '{8'h5A});
		check(8'(writeCount - w), 8'h01);
	endtask

	// page write crossing the row end wraps inside the row
	task automatic sc_page_wrap();
		wrQ = '{8'h11, 8'h22, 8'h33, 8'h44};
		run_cmd(OP_WRITE, 16'h0AFE, 8'h01);
		read_chk(16'h0AC0, '{8'h33, 8'h44});
		read_chk(16'h0AFE, '{8'h11, 8'h22, 8'hFF});
		read_chk(16'h0AFE, '{8'h11});
		run_cmd(OP_CUR, 16'h0000, 8'h01);
		check(rdQ[0], 8'h22);
	endtask

	// protected write leaves memory alone and starts no write cycle
	task automatic sc_protect();
		int w;
		w = writeCount;
		#1 wp = 1'b1;
		wrQ = '{8'h01, 8'h02};
		run_cmd(OP_WRITE, 16'h0200, 8'h01);
		check({7'h00, dataNack}, 8'h01);
		read_chk(16'h0200, '{8'hFF, 8'hFF});
		read_chk(16'h0123, '{8'h5A});
		check(8'(writeCount - w), 8'h00);
		#1 wp = 1'b0;
	endtask

	// last address rolls over to zero in a sequential read
	task automatic sc_top_wrap();
		wrQ = '{8'hC3};
		run_cmd(OP_WRITE, 16'h7FFF, 8'h01);
		read_chk(16'h7FFF, '{8'hC3, 8'hFF});
		run_cmd(OP_CUR, 16'h0000, 8'h01);
		check(rdQ[0], 8'hFF);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence and watchdog
	initial
	begin
		rst_n = 1'b0;
		wp = 1'b0;
		reqValid = 1'b0;
		reqOp = OP_WRITE;
		reqAddr = 16'h0000;
		reqLen = 8'h01;
		wrData = 8'h00;
		wrValid = 1'b0;
		failCount = 0;
		cmpCount = 0;
		writeCount = 0;
		repeat (4) @(posedge mclk);
		#1 rst_n = 1'b1;
		@(posedge mclk);
		#1;
		sc_byte_write();
		sc_page_wrap();
		sc_protect();
		sc_top_wrap();
		test_done();
	end

	initial
	begin
		#10_000_000;
		failCount++;
		test_done();
	end
endmodule
